//--- core/fcwi_defs.vh
// constants for the flash command write front end
`ifndef FCWI_DEFS_VH
`define FCWI_DEFS_VH
// widths
`define FCWI_AW           22
`define FCWI_DW           16
// unlock cycle addresses (low 11 bits compared)
`define FCWI_UNL_A1       11'h555
`define FCWI_UNL_A2       11'h2AA
// command data codes
`define FCWI_C_UNL1       8'hAA
`define FCWI_C_UNL2       8'h55
`define FCWI_C_PROG       8'hA0
`define FCWI_C_ERASE      8'h80
`define FCWI_C_CHIP       8'h10
`define FCWI_C_SECT       8'h30
`define FCWI_C_IDENT      8'h90
`define FCWI_C_RESET      8'hF0
`define FCWI_C_BYPASS     8'h20
`define FCWI_C_BPEXIT     8'h00
`define FCWI_C_SUSP       8'hB0
`define FCWI_C_RESUME     8'h30
`define FCWI_C_CFG        8'hD0
// config data bit that selects synchronous reads
`define FCWI_CFG_SYNC_BIT 15
// operation codes to the program/erase engine
`define FCWI_OP_PROG      3'h1
`define FCWI_OP_ERSECT    3'h2
`define FCWI_OP_ERCHIP    3'h3
`define FCWI_OP_SUSP      3'h4
`define FCWI_OP_RESUME    3'h5
// identification register offsets
`define FCWI_ID_MAKER_OFS 8'h00
`define FCWI_ID_PART_OFS  8'h01
`define FCWI_ID_PROT_OFS  8'h02
// identity values (arbitrary)
`define FCWI_ID_MAKER     16'h005A
`define FCWI_ID_PART      16'h1234
// bank codes on the top three address bits
`define FCWI_BANK_A       2'h0
`define FCWI_BANK_B       2'h1
`define FCWI_BANK_C       2'h2
`define FCWI_BANK_D       2'h3
// extra sector window after an erase sector write
`define FCWI_CLK_NS       40
`define FCWI_ERWIN_NS     50000
`define FCWI_ERWIN_CYC    (`FCWI_ERWIN_NS / `FCWI_CLK_NS)
`endif

//--- core/fcwi_core.v
// flash command write front end: pin capture, command decode, read mux
`include "fcwi_defs.vh"
`default_nettype none
module fcwi_core #(
  parameter AW      = `FCWI_AW,
  parameter DW      = `FCWI_DW,
  parameter ERWIN   = `FCWI_ERWIN_CYC
) (
  // clock and reset
  input  wire          clk,
  input  wire          rstn,
  // flash bus pins
  input  wire          ce_n,
  input  wire          we_n,
  input  wire          oe_n,
  input  wire          address_valid_n,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] data_lines_in,
  output wire [DW-1:0] data_lines_out,
  output wire          data_lines_oe,
  // level detectors on special pins
  input  wire          accelerate_input_boost,
  input  wire          accelerate_input_low,
  input  wire          address_bit_nine_id,
  // array and engine side
  output wire [AW-1:0] arr_rd_addr,
  input  wire [DW-1:0] arr_rd_data,
  input  wire [3:0]    bank_busy,
  input  wire          erase_suspended,
  input  wire [7:0]    erase_unit,
  input  wire [DW-1:0] engine_status,
  input  wire          unit_protected,
  output wire [7:0]    query_unit,
  output reg           op_valid,
  output reg  [2:0]    op_code,
  output reg  [AW-1:0] op_addr,
  output reg  [DW-1:0] op_data,
  // mode status
  output wire          sync_read_mode,
  output wire          shortcut_mode,
  output wire          all_locked,
  output wire          ident_active
);

  // states of the command decoder
  localparam ST_IDLE = 4'd0;
  localparam ST_UNL1 = 4'd1;
  localparam ST_UNL2 = 4'd2;
  localparam ST_PROG = 4'd3;
  localparam ST_ER1  = 4'd4;
  localparam ST_ER2  = 4'd5;
  localparam ST_ER3  = 4'd6;
  localparam ST_ERW  = 4'd7;
  localparam ST_CFG  = 4'd8;
  localparam ST_BPX  = 4'd9;
  localparam PW      = 7;
  localparam BW      = AW + DW;

  // bank from the top three address bits: 000 A, 111 D, else B or C
  function [1:0] bank_of;
    input [AW-1:0] a;
    begin
      if (a[21:19] == 3'b000)
        bank_of = `FCWI_BANK_A;
      else if (a[21:19] == 3'b111)
        bank_of = `FCWI_BANK_D;
      else if (a[21] == 1'b0)
        bank_of = `FCWI_BANK_B;
      else
        bank_of = `FCWI_BANK_C;
    end
  endfunction

  // protection unit index from address bits 21..12
  function [7:0] unit_of;
    input [AW-1:0] a;
    reg   [9:0]    u;
    begin
      u = a[21:12];
      if (u[9:3] == 7'h00)
        unit_of = {5'h00, u[2:0]};
      else if (u[9:3] <= 7'h03)
        unit_of = 8'd7 + {1'b0, u[9:3]};
      else if (u[9:3] >= 7'h7F)
        unit_of = 8'd134 + {5'h00, u[2:0]};
      else if (u[9:3] >= 7'h7C)
        unit_of = 8'd131 + {6'h00, u[4:3]};
      else
        unit_of = 8'd11 + {u[9:5] - 5'h01, 2'b00};
    end
  endfunction

  // three-flop pin sync; a change counts once stages two and three agree
  reg [PW-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
  reg [BW-1:0] b1_ff, b2_ff, b3_ff, b4_ff;
  wire [PW-1:0] pin_raw = {address_bit_nine_id, accelerate_input_low, accelerate_input_boost,
                           address_valid_n, oe_n, we_n, ce_n};
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff  <= 7'h0F;
      s2_ff  <= 7'h0F;
      s3_ff  <= 7'h0F;
      pin_ff <= 7'h0F;
      b1_ff  <= {BW{1'b0}};
      b2_ff  <= {BW{1'b0}};
      b3_ff  <= {BW{1'b0}};
      b4_ff  <= {BW{1'b0}};
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      b1_ff <= {addr, data_lines_in};
      b2_ff <= b1_ff;
      b3_ff <= b2_ff;
      b4_ff <= b3_ff;
      pin_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (pin_ff & (s2_ff ^ s3_ff));
    end
  end

  // filtered pin levels; bus stage four covers the filter's agreement cycle,
  // so address and data are those present at the strobe edge, not after it
  wire          ce_f   = pin_ff[0];
  wire          we_f   = pin_ff[1];
  wire          oe_f   = pin_ff[2];
  wire          avd_f  = pin_ff[3];
  wire          boost  = pin_ff[4];
  wire          acc_lo = pin_ff[5];
  wire          idhv   = pin_ff[6];
  wire [AW-1:0] bus_a  = b4_ff[BW-1:DW];
  wire [DW-1:0] bus_d  = b4_ff[DW-1:0];

  // write window is open while both strobes are low and output enable is high
  wire wr_now = ~we_f & ~ce_f & oe_f;
  reg  wr_ff;
  reg  [AW-1:0] wa_ff;
  reg  [AW-1:0] sa_ff;
  reg           sa_vld_ff;
  reg           sync_ff;
  wire wr_start = wr_now & ~wr_ff;
  wire wr_end   = ~wr_now & wr_ff;
  // async reads ignore address-valid, so the clock latch only exists in sync mode
  wire avd_latch = sync_ff & ~avd_f & ~ce_f & oe_f & we_f;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ff     <= 1'b0;
      wa_ff     <= {AW{1'b0}};
      sa_ff     <= {AW{1'b0}};
      sa_vld_ff <= 1'b0;
    end else begin
      wr_ff <= wr_now;
      if (avd_latch) begin
        sa_ff     <= bus_a;
        sa_vld_ff <= 1'b1;
      end else if (wr_end | ce_f) begin
        sa_vld_ff <= 1'b0;
      end
      // address on the later of the two falls, clock latch wins in sync mode
      if (wr_start)
        wa_ff <= sa_vld_ff ? sa_ff : bus_a;
    end
  end

  // a completed write cycle: data taken on the first rising strobe
  wire          wcyc = wr_end;
  wire [AW-1:0] wadr = wa_ff;
  wire [DW-1:0] wdat = bus_d;
  wire [7:0]    wcmd = wdat[7:0];
  wire          a1   = wadr[10:0] == `FCWI_UNL_A1;
  wire          a2   = wadr[10:0] == `FCWI_UNL_A2;

  // decoder state and mode flags
  reg [3:0]  st_ff, nxt_st;
  reg        byp_ff, nxt_byp;
  reg        id_ff, nxt_id;
  reg [1:0]  idb_ff, nxt_idb;
  reg        nxt_sync;
  reg [10:0] win_ff, nxt_win;
  reg        nxt_opv;
  reg [2:0]  nxt_opc;
  wire       shortcut = byp_ff | boost;
  // a low accelerate level locks every unit against program and erase
  wire       locked   = acc_lo;
  wire [7:0] w_unit   = unit_of(wadr);
  // program during suspend is refused only in the unit being erased
  wire       susp_hit = erase_suspended & (w_unit == erase_unit);

  // command sequence decode
  always @* begin
    nxt_st   = st_ff;
    nxt_byp  = byp_ff;
    nxt_id   = id_ff;
    nxt_idb  = idb_ff;
    nxt_sync = sync_ff;
    nxt_win  = (win_ff != 11'd0) ? win_ff - 11'd1 : 11'd0;
    nxt_opv  = 1'b0;
    nxt_opc  = `FCWI_OP_PROG;
    if (st_ff == ST_ERW && win_ff == 11'd0)
      nxt_st = ST_IDLE;
    if (wcyc) begin
      nxt_st = ST_IDLE;
      if (wcmd == `FCWI_C_RESET && st_ff != ST_PROG) begin
        nxt_id = 1'b0;
      end else begin
        case (st_ff)
          ST_IDLE: begin
            if (shortcut && wcmd == `FCWI_C_PROG)
              nxt_st = ST_PROG;
            else if (byp_ff && wcmd == `FCWI_C_IDENT)
              nxt_st = ST_BPX;
            else if (wcmd == `FCWI_C_SUSP) begin
              nxt_opv = 1'b1;
              nxt_opc = `FCWI_OP_SUSP;
            end else if (wcmd == `FCWI_C_RESUME && erase_suspended) begin
              nxt_opv = 1'b1;
              nxt_opc = `FCWI_OP_RESUME;
            end else if (a1 && wcmd == `FCWI_C_UNL1)
              nxt_st = ST_UNL1;
          end
          ST_UNL1: begin
            if (a2 && wcmd == `FCWI_C_UNL2)
              nxt_st = ST_UNL2;
          end
          ST_UNL2: begin
            if (wcmd == `FCWI_C_PROG)
              nxt_st = ST_PROG;
            else if (a1 && wcmd == `FCWI_C_ERASE)
              nxt_st = ST_ER1;
            else if (a1 && wcmd == `FCWI_C_BYPASS)
              nxt_byp = 1'b1;
            else if (wcmd == `FCWI_C_CFG)
              nxt_st = ST_CFG;
            else if (wcmd == `FCWI_C_IDENT && !sync_ff) begin
              // entry via command, bank picked by the top address bits
              nxt_id  = 1'b1;
              nxt_idb = bank_of(wadr);
            end
          end
          ST_PROG: begin
            if (!locked && !susp_hit) begin
              nxt_opv = 1'b1;
              nxt_opc = `FCWI_OP_PROG;
            end
          end
          ST_ER1: begin
            if (a1 && wcmd == `FCWI_C_UNL1)
              nxt_st = ST_ER2;
          end
          ST_ER2: begin
            if (a2 && wcmd == `FCWI_C_UNL2)
              nxt_st = ST_ER3;
          end
          ST_ER3, ST_ERW: begin
            if (st_ff == ST_ER3 && a1 && wcmd == `FCWI_C_CHIP) begin
              nxt_opv = !locked;
              nxt_opc = `FCWI_OP_ERCHIP;
            end else if (wcmd == `FCWI_C_SECT) begin
              // each sector write within the window adds one more sector
              nxt_opv = !locked;
              nxt_opc = `FCWI_OP_ERSECT;
              nxt_st  = ST_ERW;
              nxt_win = ERWIN[10:0];
            end
          end
          ST_CFG: begin
            nxt_sync = wdat[`FCWI_CFG_SYNC_BIT];
            if (wdat[`FCWI_CFG_SYNC_BIT])
              nxt_id = 1'b0;
          end
          ST_BPX: begin
            if (wcmd == `FCWI_C_BPEXIT)
              nxt_byp = 1'b0;
          end
          default: nxt_st = ST_IDLE;
        endcase
      end
    end
  end

  // decoder registers and operation handoff
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff    <= ST_IDLE;
      byp_ff   <= 1'b0;
      id_ff    <= 1'b0;
      idb_ff   <= `FCWI_BANK_A;
      sync_ff  <= 1'b0;
      win_ff   <= 11'd0;
      op_valid <= 1'b0;
      op_code  <= 3'd0;
      op_addr  <= {AW{1'b0}};
      op_data  <= {DW{1'b0}};
    end else begin
      st_ff    <= nxt_st;
      byp_ff   <= nxt_byp;
      id_ff    <= nxt_id;
      idb_ff   <= nxt_idb;
      sync_ff  <= nxt_sync;
      win_ff   <= nxt_win;
      op_valid <= nxt_opv;
      if (nxt_opv) begin
        op_code <= nxt_opc;
        op_addr <= wadr;
        op_data <= wdat;
      end
    end
  end

  // read side: address from the bus pipe, answer registered
  wire       rd_act   = ~ce_f & ~oe_f & we_f;
  wire [1:0] rd_bank  = bank_of(bus_a);
  // high level on address bit nine opens identification for programmers, in async mode only
  wire       id_pin   = idhv & ~sync_ff;
  wire       id_here  = id_pin | (id_ff & (rd_bank == idb_ff));
  wire       busy_rd  = bank_busy[rd_bank] & ~erase_suspended;
  reg [DW-1:0] rdat_ff, nxt_rdat;
  reg          oe_ff;

  // identification register is apart from the array
  always @* begin
    nxt_rdat = arr_rd_data;
    if (id_here) begin
      case (bus_a[7:0])
        `FCWI_ID_MAKER_OFS: nxt_rdat = `FCWI_ID_MAKER;
        `FCWI_ID_PART_OFS:  nxt_rdat = `FCWI_ID_PART;
        `FCWI_ID_PROT_OFS:  nxt_rdat = {{(DW-1){1'b0}}, unit_protected | locked};
        default:            nxt_rdat = {DW{1'b0}};
      endcase
    end else if (busy_rd) begin
      // only the bank being worked shows status; others read the array
      nxt_rdat = engine_status;
    end
  end

  // read data and drive enable flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdat_ff <= {DW{1'b0}};
      oe_ff   <= 1'b0;
    end else begin
      rdat_ff <= nxt_rdat;
      oe_ff   <= rd_act;
    end
  end

  // outputs
  assign data_lines_out = rdat_ff;
  assign data_lines_oe  = oe_ff & rd_act;
  assign arr_rd_addr    = bus_a;
  assign query_unit     = unit_of(bus_a);
  assign sync_read_mode = sync_ff;
  assign shortcut_mode  = shortcut;
  assign all_locked     = locked;
  assign ident_active   = id_ff | id_pin;

endmodule
`default_nettype wire

//--- test/fcwi_chk.sv
// pin-level assertions for the flash command write front end
`include "fcwi_defs.vh"
`default_nettype none
module fcwi_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // host strobes and special pins
  input wire logic        ce_n,
  input wire logic        we_n,
  input wire logic        oe_n,
  input wire logic        accelerate_input_boost,
  input wire logic        accelerate_input_low,
  // device outputs
  input wire logic        data_lines_oe,
  input wire logic        op_valid,
  input wire logic [2:0]  op_code,
  input wire logic        sync_read_mode,
  input wire logic        shortcut_mode,
  input wire logic        all_locked,
  input wire logic        ident_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // boost level must reach the mode flag through the pin filter
  a_boost_short: assert property ($rose(accelerate_input_boost) |-> ##[1:6] shortcut_mode)
    else $error("shortcut mode not entered");
  a_lock_follow: assert property ($rose(accelerate_input_low) |-> ##[1:6] all_locked)
    else $error("lock not raised");
  a_lock_release: assert property ($fell(accelerate_input_low) |-> ##[1:6] !all_locked)
    else $error("lock not dropped");
  // a settled lock refuses program and erase work
  a_locked_noop: assert property (all_locked [*8] |-> !(op_valid && op_code inside
    {`FCWI_OP_PROG, `FCWI_OP_ERSECT, `FCWI_OP_ERCHIP})) else $error("operation while locked");
  a_op_pulse: assert property (op_valid |=> !op_valid)
    else $error("operation pulse too long");
  // data is taken at the first strobe rise, so a rise comes first
  a_op_after_rise: assert property (op_valid |-> $past(we_n, 3) || $past(ce_n, 3))
    else $error("operation before strobe release");
  a_ident_async: assert property (ident_active |-> !sync_read_mode)
    else $error("identification in sync mode");
  a_read_start: assert property ($rose(data_lines_oe) |-> !$past(oe_n, 3) && !$past(oe_n, 2))
    else $error("bus driven without read");
  a_oe_release: assert property ($rose(oe_n) |-> ##[2:6] !data_lines_oe)
    else $error("bus not released");
endmodule
bind fcwi_core fcwi_chk chk_u (.clk(clk), .rstn(rstn), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
  .accelerate_input_boost(accelerate_input_boost), .accelerate_input_low(accelerate_input_low),
  .data_lines_oe(data_lines_oe), .op_valid(op_valid), .op_code(op_code), .sync_read_mode(sync_read_mode),
  .shortcut_mode(shortcut_mode), .all_locked(all_locked), .ident_active(ident_active));
`default_nettype wire

//--- test/fcwi_host.sv
// host memory controller model driving the flash bus pins
`default_nettype none
module fcwi_host (
  // clock
  input  wire logic        clk,
  // bus pins toward the device
  output var  logic        ce_n,
  output var  logic        we_n,
  output var  logic        oe_n,
  output var  logic        address_valid_n,
  output var  logic [21:0] addr,
  output var  logic [15:0] dout
);
  timeunit 1ns;
  timeprecision 1ns;
  // strobes idle high from time zero
  initial begin
    {ce_n, we_n, oe_n, address_valid_n} = 4'hf;
    addr = 22'h0;
    dout = 16'h0;
  end
  task hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // four cycles per phase: the pin filter needs three
  task wr(input logic [21:0] a, input logic [15:0] d, input logic sy = 1'b0);
    addr = a;
    if (sy) begin
      ce_n = 0;
      address_valid_n = 0;
      hold(4);
      address_valid_n = 1;
      addr = ~a; // address no longer valid once latched
    end
    dout = d;
    ce_n = 0;
    we_n = 0;
    hold(4);
    we_n = 1;
    ce_n = 1;
    hold(1);
    addr = ~addr; // released lines do not keep their last value
    dout = ~d;
    hold(5);
  endtask
  task rd(input logic [21:0] a);
    addr = a;
    ce_n = 0;
    oe_n = 0;
    hold(7);
    oe_n = 1;
    ce_n = 1;
    hold(1);
    addr = ~a;
    hold(3);
  endtask
endmodule
`default_nettype wire

//--- test/flash_command_write_interface_test.sv
// self-checking bench for the flash command write front end
`include "fcwi_defs.vh"
`default_nettype none
module flash_command_write_interface_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [40:0] ALL = {41{1'b1}};
  logic        clk = 0, rstn = 0, boost = 0, low = 0, nine = 0, oe_q = 0;
  logic [3:0]  busy = 0;
  logic        susp = 0;
  logic [7:0]  eu = 0, pu = 0, qu;
  logic [15:0] stat = 16'hbeef;
  logic        ce_n, we_n, oe_n, avd_n, dloe, opv, sync_m, short_m, lock_m, ident_m;
  logic [21:0] addr, ra, opa, a;
  logic [15:0] dout, rdat, opd, d;
  logic [2:0]  opc;
  logic [40:0] m;
  logic [40:0] opq[$], mq[$], rdq[$];
  int          errors = 0, check_count = 0, cyc = 0, seed = 32'hb620;
  initial begin
    forever #20 clk = ~clk;
  end
  // array model returns a pattern of the address it is asked for; only unit pu is protected
  fcwi_core #(.ERWIN(20)) dut_u (.clk(clk), .rstn(rstn), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .address_valid_n(avd_n), .addr(addr), .data_lines_in(dout), .data_lines_out(rdat), .data_lines_oe(dloe),
    .accelerate_input_boost(boost), .accelerate_input_low(low), .address_bit_nine_id(nine), .arr_rd_addr(ra),
    .arr_rd_data(ra[15:0] ^ 16'h5a5a), .bank_busy(busy), .erase_suspended(susp), .erase_unit(eu),
    .engine_status(stat), .unit_protected(qu == pu), .query_unit(qu), .op_valid(opv), .op_code(opc),
    .op_addr(opa), .op_data(opd), .sync_read_mode(sync_m), .shortcut_mode(short_m), .all_locked(lock_m),
    .ident_active(ident_m));
  fcwi_host host_u (.clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .address_valid_n(avd_n),
    .addr(addr), .dout(dout));
  task chk(input logic [40:0] seen, input logic [40:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // the mask hides fields an erase leaves undefined
  task exp_op(input logic [2:0] c, input logic [21:0] ea, input logic [15:0] ed, input logic [40:0] mk);
    opq.push_back({c, ea, ed} & mk);
    mq.push_back(mk);
  endtask
  task unl;
    host_u.wr({11'h000, `FCWI_UNL_A1}, {8'h00, `FCWI_C_UNL1});
    host_u.wr({11'h000, `FCWI_UNL_A2}, {8'h00, `FCWI_C_UNL2});
  endtask
  task cmd3(input logic [2:0] t, input logic [7:0] c);
    unl();
    host_u.wr({t, 8'h00, `FCWI_UNL_A1}, {8'h00, c});
  endtask
  // async mode ignores the address-valid latch, so the later address counts
  task prog(input bit four, input bit sy, input bit keep);
    a = $random(seed);
    d = $random(seed);
    // a stray suspend code in idle would start an operation nobody expects
    if (!keep && d[7:0] == `FCWI_C_SUSP) d[7:0] = 8'h00;
    if (four) cmd3(3'h0, `FCWI_C_PROG);
    else host_u.wr(a, {8'h00, `FCWI_C_PROG});
    if (keep) exp_op(`FCWI_OP_PROG, (sy && sync_m !== 1'b1) ? ~a : a, d, ALL);
    host_u.wr(a, d, sy);
  endtask
  task erase(input logic [21:0] ea, input logic [7:0] c, input logic [40:0] mk);
    cmd3(3'h0, `FCWI_C_ERASE);
    unl();
    if (mk != 0) exp_op(c == `FCWI_C_CHIP ? `FCWI_OP_ERCHIP : `FCWI_OP_ERSECT, ea, 16'h0, mk);
    host_u.wr(ea, {8'h00, c});
    host_u.hold(30);
  endtask
  task rd(input logic [21:0] ad, input logic [15:0] e);
    rdq.push_back(e);
    host_u.rd(ad);
  endtask
  // watcher: each result is matched against the oldest note
  always @(negedge clk) begin
    oe_q <= dloe;
    if (opv === 1'b1) begin
      m = mq.size() ? mq.pop_front() : ALL;
      chk({opc, opa, opd} & m, opq.size() ? opq.pop_front() : 41'h0);
    end
    if (dloe === 1'b1 && oe_q !== 1'b1) chk(rdat, rdq.size() ? rdq.pop_front() : 41'h1_0000);
  end
  // hang guard, well above the roughly eleven hundred cycles expected
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1;
    host_u.hold(2);
    prog(1, 0, 1);
    prog(1, 0, 1);
    prog(1, 1, 1);
    $display("program tests done");
    host_u.wr(22'h00_0555, 16'h00aa);
    host_u.wr(22'h00_02aa, 16'h0011);
    prog(0, 0, 0);
    $display("abort test done");
    cmd3(3'h0, `FCWI_C_BYPASS);
    chk(short_m, 1'b1);
    prog(0, 0, 1);
    prog(0, 0, 1);
    host_u.wr(22'h0, {8'h00, `FCWI_C_IDENT});
    host_u.wr(22'h0, {8'h00, `FCWI_C_BPEXIT});
    chk(short_m, 1'b0);
    boost = 1;
    host_u.hold(8);
    chk(short_m, 1'b1);
    prog(0, 0, 1);
    boost = 0;
    host_u.hold(8);
    chk(short_m, 1'b0);
    $display("shortcut tests done");
    low = 1;
    host_u.hold(8);
    chk(lock_m, 1'b1);
    prog(1, 0, 0);
    erase(22'h00_0555, `FCWI_C_CHIP, 41'h0);
    low = 0;
    host_u.hold(8);
    chk(lock_m, 1'b0);
    erase(22'h10_0000, `FCWI_C_SECT, {3'h7, 22'h3f_ffff, 16'h0});
    erase(22'h00_0555, `FCWI_C_CHIP, {3'h7, 38'h0});
    $display("lock and erase tests done");
    busy = 4'h1;
    stat = $random(seed);
    rd(22'h00_1234, stat);
    rd(22'h10_1234, 16'h1234 ^ 16'h5a5a);
    busy = 4'h0;
    cmd3(3'h7, `FCWI_C_IDENT);
    chk(ident_m, 1'b1);
    rd(22'h38_0000, `FCWI_ID_MAKER);
    rd(22'h38_0001, `FCWI_ID_PART);
    rd(22'h00_0007, 16'h0007 ^ 16'h5a5a);
    host_u.wr(22'h0, {8'h00, `FCWI_C_RESET});
    chk(ident_m, 1'b0);
    nine = 1;
    host_u.hold(6);
    rd(22'h00_0000, `FCWI_ID_MAKER);
    pu = 8'd133;
    rd(22'h3f_0002, 16'h0001);
    rd(22'h3f_8002, 16'h0000);
    nine = 0;
    host_u.hold(6);
    $display("read tests done");
    exp_op(`FCWI_OP_SUSP, 22'h0, {8'h00, `FCWI_C_SUSP}, ALL);
    host_u.wr(22'h0, {8'h00, `FCWI_C_SUSP});
    susp = 1;
    eu = 8'd9;
    busy = 4'h1;
    rd(22'h00_1234, 16'h1234 ^ 16'h5a5a);
    busy = 4'h0;
    cmd3(3'h0, `FCWI_C_PROG);
    host_u.wr(22'h01_0004, 16'h1111);
    exp_op(`FCWI_OP_PROG, 22'h02_0004, 16'h2222, ALL);
    cmd3(3'h0, `FCWI_C_PROG);
    host_u.wr(22'h02_0004, 16'h2222);
    exp_op(`FCWI_OP_RESUME, 22'h0, {8'h00, `FCWI_C_RESUME}, ALL);
    host_u.wr(22'h0, {8'h00, `FCWI_C_RESUME});
    susp = 0;
    $display("suspend tests done");
    cmd3(3'h0, `FCWI_C_CFG);
    host_u.wr(22'h0, 16'h8000);
    chk(sync_m, 1'b1);
    prog(1, 1, 1);
    prog(1, 0, 1);
    cmd3(3'h7, `FCWI_C_IDENT);
    chk(ident_m, 1'b0);
    cmd3(3'h0, `FCWI_C_CFG);
    host_u.wr(22'h0, 16'h0000);
    chk(sync_m, 1'b0);
    $display("sync mode tests done");
    host_u.hold(20);
    chk(opq.size() + rdq.size(), 0);
    results();
  end
endmodule
`default_nettype wire
